// *** rtl/fpu_cmp_pkg.sv ***
// fpu_cmp_pkg: shared types and constants for the compare/classify slice
// assumes 80-bit extended reals: sign 79, exponent 78:64, significand 63:0
package fpu_cmp_pkg;

  // value class of one stack entry
  typedef enum logic [2:0] {
    CLS_UNSUP,
    CLS_NAN,
    CLS_NORMAL,
    CLS_INF,
    CLS_ZERO,
    CLS_EMPTY,
    CLS_DENORM
  } fp_class_e;

  // classifier result
  typedef struct packed {
    fp_class_e cls;      // value class
    logic      is_snan;  // signalling nan
    logic      sign;     // sign bit, valid even when empty
  } class_s;

  // two opcode bytes from the issue logic
  typedef struct packed {
    logic [7:0] hi;      // escape byte
    logic [7:0] lo;      // modrm byte, low three bits are the index
  } opcode_s;

  // fault indications, one-cycle pulses
  typedef struct packed {
    logic unavail;       // device unavailable
    logic invalid;       // invalid operand
    logic stack;         // stack underflow or overflow
    logic denormal;      // denormal operand
    logic zero_div;      // zero source on split
  } fault_s;

  // opcode bytes
  localparam logic [7:0] OPC_DD       = 8'hDD;
  localparam logic [7:0] OPC_DA       = 8'hDA;
  localparam logic [7:0] OPC_D9       = 8'hD9;
  localparam logic [7:0] OPC_UCOM     = 8'hE0;
  localparam logic [7:0] OPC_UCOMP    = 8'hE8;
  localparam logic [7:0] OPC_UCOMPP   = 8'hE9;
  localparam logic [7:0] OPC_CLASSIFY = 8'hE5;
  localparam logic [7:0] OPC_XCH      = 8'hC8;
  localparam logic [7:0] OPC_SPLIT    = 8'hF4;
  localparam logic [7:0] OPC_IDX_MASK = 8'hF8;

  // field positions of the extended format
  localparam int SIGN_POS = 79;
  localparam int EXP_HI   = 78;
  localparam int EXP_LO   = 64;
  localparam int INT_BIT  = 63;
  localparam int QUIET_BIT = 62;

  // exponent constants
  localparam logic [14:0] EXP_BIAS = 15'h3FFF;
  localparam logic [14:0] EXP_MAX  = 15'h7FFF;

  // condition code triples {cc_bit3, cc_bit2, cc_bit0}
  localparam logic [2:0] CC_GT    = 3'h0;
  localparam logic [2:0] CC_LT    = 3'h1;
  localparam logic [2:0] CC_EQ    = 3'h4;
  localparam logic [2:0] CC_UNORD = 3'h7;

  // reset values
  localparam logic [2:0] TOP_RST  = 3'h0;
  localparam logic [3:0] CC_RST   = 4'h0;

endpackage : fpu_cmp_pkg

// *** rtl/fp_classify.sv ***
// fp_classify: combinational class decode of one 80-bit stack entry
// assumes the tag bit says whether the entry is empty
`timescale 1ns/100ps
`default_nettype none

module fp_classify (
  // entry under test
  input  wire logic [79:0]          value,
  input  wire logic                 empty,
  // decoded class
  output fpu_cmp_pkg::class_s       info
);

  wire [14:0] exp_f  = value[fpu_cmp_pkg::EXP_HI:fpu_cmp_pkg::EXP_LO];
  wire        int_b  = value[fpu_cmp_pkg::INT_BIT];
  wire        frac_z = (value[62:0] == 63'h0);  // fraction below int bit
  wire        exp_z  = (exp_f == 15'h0);
  wire        exp_m  = (exp_f == fpu_cmp_pkg::EXP_MAX);

  // class priority: empty tag first, then encodings
  always_comb begin
    info.sign    = value[fpu_cmp_pkg::SIGN_POS];
    info.is_snan = 1'b0;
    if (empty) begin
      info.cls = fpu_cmp_pkg::CLS_EMPTY;
    end else if (exp_z) begin
      // pseudo-denormals with int bit set are lumped with denormals
      info.cls = (int_b || !frac_z) ? fpu_cmp_pkg::CLS_DENORM
                                    : fpu_cmp_pkg::CLS_ZERO;
    end else if (!int_b) begin
      // unnormals, pseudo-nan and pseudo-infinity are not supported
      info.cls = fpu_cmp_pkg::CLS_UNSUP;
    end else if (exp_m) begin
      info.cls     = frac_z ? fpu_cmp_pkg::CLS_INF : fpu_cmp_pkg::CLS_NAN;
      info.is_snan = !frac_z && !value[fpu_cmp_pkg::QUIET_BIT];
    end else begin
      info.cls = fpu_cmp_pkg::CLS_NORMAL;
    end
  end

endmodule : fp_classify
`default_nettype wire

// *** rtl/fpu_compare_classify_exchange.sv ***
// fpu_compare_classify_exchange: register stack with unordered compare,
// classify, exchange and exponent/significand split, one op per cycle.
// assumes issue logic holds op_valid for one cycle per instruction.
//
// Contract
// - decode ucompare, ucompare_pop, ucompare_pop2 opcodes
// - no operand means compare top with second
// - negative and positive zero compare equal
// - compare codes 000 gt, 001 lt, 100 eq, 111
// - quiet nan unordered without invalid fault
// - invalid fault writes codes only when masked
// - pop tags top empty, pointer plus one
// - underflow stack fault clears cc_bit1; denormal fault
// - decode classify_top on top entry only
// - classify codes per class table
// - classify copies sign to cc_bit1, even empty
// - decode exchange_top, fixed form uses second entry
// - exchange underflow faults; cc_bit1 always cleared
// - split: exponent in place, pointer down, push
// - new top keeps sign, significand, exponent 3FFF
// - zero source: zero divide, masked gives -inf
// - split stack fault; cc_bit1 0 under, 1 over
// - split snan or unsupported raises invalid fault
// - emulation or task switched flag blocks execution
`timescale 1ns/100ps
`default_nettype none

module fpu_compare_classify_exchange #(
  parameter int DEPTH = 8                 // stack entries
) (
  // clock and reset
  input  wire logic                 clk,
  input  wire logic                 rst_n,
  // instruction issue
  input  wire logic                 op_valid,
  input  wire fpu_cmp_pkg::opcode_s opcode,
  // control state
  input  wire logic                 emulation_flag,
  input  wire logic                 task_switched_flag,
  input  wire logic                 invalid_op_mask,
  input  wire logic                 zero_divide_mask,
  // stack load port, physical index
  input  wire logic                 load_valid,
  input  wire logic [2:0]           load_index,
  input  wire logic [79:0]          load_data,
  input  wire logic                 load_empty,
  // stack read port, physical index
  input  wire logic [2:0]           read_index,
  // results
  output logic [3:0]                cond_code,
  output logic [2:0]                stack_pointer_field,
  output fpu_cmp_pkg::fault_s       faults,
  output logic                      op_done,
  output logic [79:0]               read_data,
  output logic                      read_empty
);

  // architectural state
  logic [79:0]         regs_ff [DEPTH];     // stack entries
  logic                empty_ff [DEPTH];    // empty tags, one flop each
  logic [2:0]          top_ff;              // stack pointer
  logic [3:0]          cc_ff;               // {c3,c2,c1,c0} by bit number
  fpu_cmp_pkg::fault_s fault_ff;            // fault pulses
  logic                done_ff;             // op retired pulse
  logic [79:0]         rd_ff;               // read port data
  logic                rd_empty_ff;         // read port tag

  // next-state values
  logic [2:0]          nxt_top;
  logic [3:0]          nxt_cc;
  fpu_cmp_pkg::fault_s nxt_fault;
  logic                wa_en, wb_en;        // two entry write ports
  logic [2:0]          wa_idx, wb_idx;
  logic [79:0]         wa_dat, wb_dat;
  logic [1:0]          pop_n;               // pops to perform

  // leading zero count of a 64-bit word, 64 when all zero
  function automatic logic [6:0] lead_zeros(input logic [63:0] v);
    logic       found;
    logic [6:0] n;
    found = 1'b0;
    n     = 7'h40;
    for (int k = 63; k >= 0; k--) begin
      if (!found && v[k]) begin
        n     = 7'(63 - k);
        found = 1'b1;
      end
    end
    return n;
  endfunction : lead_zeros

  // opcode decode
  wire [7:0] lo_b      = opcode.lo;
  wire [7:0] lo_base   = lo_b & fpu_cmp_pkg::OPC_IDX_MASK;
  wire [2:0] idx_i     = lo_b[2:0];
  wire is_ucom   = opcode.hi == fpu_cmp_pkg::OPC_DD
                && lo_base == fpu_cmp_pkg::OPC_UCOM;
  wire is_ucomp  = opcode.hi == fpu_cmp_pkg::OPC_DD
                && lo_base == fpu_cmp_pkg::OPC_UCOMP;
  wire is_ucompp = opcode.hi == fpu_cmp_pkg::OPC_DA
                && lo_b == fpu_cmp_pkg::OPC_UCOMPP;
  wire is_class  = opcode.hi == fpu_cmp_pkg::OPC_D9
                && lo_b == fpu_cmp_pkg::OPC_CLASSIFY;
  wire is_xch    = opcode.hi == fpu_cmp_pkg::OPC_D9
                && lo_base == fpu_cmp_pkg::OPC_XCH;
  wire is_split  = opcode.hi == fpu_cmp_pkg::OPC_D9
                && lo_b == fpu_cmp_pkg::OPC_SPLIT;
  wire is_cmp    = is_ucom || is_ucomp || is_ucompp;
  wire known_op  = is_cmp || is_class || is_xch || is_split;
  // both control flags block every op here
  wire blocked   = emulation_flag || task_switched_flag;

  // operand addressing; the no-operand forms encode index 1
  wire [2:0] src_rel  = is_ucompp ? 3'h1 : idx_i;
  wire [2:0] p_top    = top_ff;
  wire [2:0] p_src    = top_ff + src_rel;
  wire [2:0] p_push   = top_ff - 3'h1;
  wire [79:0] top_v   = regs_ff[p_top];
  wire [79:0] src_v   = regs_ff[p_src];

  // classify both operands
  fpu_cmp_pkg::class_s top_c, src_c;
  fp_classify u_cls_top (
    .value (top_v),
    .empty (empty_ff[p_top]),
    .info  (top_c)
  );
  fp_classify u_cls_src (
    .value (src_v),
    .empty (empty_ff[p_src]),
    .info  (src_c)
  );

  // compare: magnitude on exponent and significand, zero sign ignored
  wire both_zero = top_c.cls == fpu_cmp_pkg::CLS_ZERO
                && src_c.cls == fpu_cmp_pkg::CLS_ZERO;
  wire mag_gt    = top_v[78:0] > src_v[78:0];
  wire mag_eq    = top_v[78:0] == src_v[78:0];
  wire sgn_diff  = top_c.sign != src_c.sign;
  wire rel_eq    = both_zero || (!sgn_diff && mag_eq);
  wire rel_gt    = sgn_diff ? !top_c.sign
                            : (top_c.sign ? (!mag_gt && !mag_eq) : mag_gt);
  wire [2:0] rel_code = rel_eq ? fpu_cmp_pkg::CC_EQ :
                        rel_gt ? fpu_cmp_pkg::CC_GT : fpu_cmp_pkg::CC_LT;

  // compare exceptions; quiet nan alone is not invalid
  wire cmp_uflow = top_c.cls == fpu_cmp_pkg::CLS_EMPTY
                || src_c.cls == fpu_cmp_pkg::CLS_EMPTY;
  wire cmp_inv   = top_c.is_snan || src_c.is_snan
                || top_c.cls == fpu_cmp_pkg::CLS_UNSUP
                || src_c.cls == fpu_cmp_pkg::CLS_UNSUP;
  wire cmp_nan   = top_c.cls == fpu_cmp_pkg::CLS_NAN
                || src_c.cls == fpu_cmp_pkg::CLS_NAN;
  wire cmp_den   = top_c.cls == fpu_cmp_pkg::CLS_DENORM
                || src_c.cls == fpu_cmp_pkg::CLS_DENORM;
  // underflow is an invalid-class fault, so it obeys the same mask
  wire cmp_bad   = cmp_inv || cmp_uflow;
  wire cmp_go    = !cmp_bad || invalid_op_mask;
  wire [2:0] cmp_code = (cmp_nan || cmp_bad) ? fpu_cmp_pkg::CC_UNORD
                                             : rel_code;

  // classify code per class
  logic [2:0] cls_code;
  always_comb begin
    case (top_c.cls)
      fpu_cmp_pkg::CLS_UNSUP:  cls_code = 3'h0;
      fpu_cmp_pkg::CLS_NAN:    cls_code = 3'h1;
      fpu_cmp_pkg::CLS_NORMAL: cls_code = 3'h2;
      fpu_cmp_pkg::CLS_INF:    cls_code = 3'h3;
      fpu_cmp_pkg::CLS_ZERO:   cls_code = 3'h4;
      fpu_cmp_pkg::CLS_EMPTY:  cls_code = 3'h5;
      fpu_cmp_pkg::CLS_DENORM: cls_code = 3'h6;
      default:                 cls_code = 3'h0;
    endcase
  end

  // exchange checks
  wire xch_uflow = cmp_uflow;

  // split: exception checks
  wire spl_uflow = top_c.cls == fpu_cmp_pkg::CLS_EMPTY;
  wire spl_oflow = !empty_ff[p_push] && !spl_uflow;
  wire spl_inv   = top_c.is_snan
                || top_c.cls == fpu_cmp_pkg::CLS_UNSUP;
  wire spl_zero  = top_c.cls == fpu_cmp_pkg::CLS_ZERO;
  wire spl_go    = !spl_uflow && !spl_oflow
                && (!spl_inv || invalid_op_mask)
                && (!spl_zero || zero_divide_mask);

  // split: significand normalised, true exponent as signed value
  wire        spl_den  = top_c.cls == fpu_cmp_pkg::CLS_DENORM;
  wire [6:0]  sig_lz   = lead_zeros(top_v[63:0]);
  wire [63:0] sig_norm = spl_den ? (top_v[63:0] << sig_lz) : top_v[63:0];
  wire [17:0] exp_u    = {3'h0, top_v[78:64]};
  wire [17:0] bias18   = {3'h0, fpu_cmp_pkg::EXP_BIAS};
  wire [17:0] true_e   = spl_den ? (18'h1 - bias18 - {11'h0, sig_lz})
                                 : (exp_u - bias18);
  // exponent converted to an extended real
  wire        e_neg    = true_e[17];
  wire [17:0] e_mag    = e_neg ? (18'h0 - true_e) : true_e;
  wire [63:0] e_wide   = {46'h0, e_mag};
  wire [6:0]  e_lz     = lead_zeros(e_wide);
  wire [14:0] e_exp    = fpu_cmp_pkg::EXP_BIAS + {8'h00, 7'h3F - e_lz};
  wire [79:0] e_real   = (e_mag == 18'h0) ? 80'h0
                       : {e_neg, e_exp, e_wide << e_lz};
  // result pair: second entry, new top
  wire [79:0] neg_inf  = {1'b1, fpu_cmp_pkg::EXP_MAX, 1'b1, 63'h0};
  wire [79:0] spl_sec  = spl_zero ? neg_inf :
                         (top_c.cls == fpu_cmp_pkg::CLS_NAN) ? top_v :
                         e_real;
  wire [79:0] spl_new  = spl_zero ? {top_c.sign, 79'h0} :
                         (top_c.cls == fpu_cmp_pkg::CLS_NAN) ? top_v :
                         {top_c.sign, fpu_cmp_pkg::EXP_BIAS,
                          sig_norm};

  // operation select: outcome of the op in this cycle
  always_comb begin
    nxt_top   = top_ff;
    nxt_cc    = cc_ff;
    nxt_fault = '0;
    wa_en     = 1'b0;
    wa_idx    = p_top;
    wa_dat    = top_v;
    wb_en     = 1'b0;
    wb_idx    = p_src;
    wb_dat    = src_v;
    pop_n     = 2'h0;
    if (op_valid && known_op && blocked) begin
      nxt_fault.unavail = 1'b1;
    end else if (op_valid && is_cmp) begin
      nxt_fault.invalid  = cmp_inv;
      nxt_fault.stack    = cmp_uflow;
      nxt_fault.denormal = cmp_den;
      if (cmp_uflow) begin
        nxt_cc[1] = 1'b0;
      end
      if (cmp_go) begin
        {nxt_cc[3], nxt_cc[2], nxt_cc[0]} = cmp_code;
        // pops follow the comparison
        pop_n   = is_ucompp ? 2'h2 : (is_ucomp ? 2'h1 : 2'h0);
        nxt_top = top_ff + {1'b0, pop_n};
      end
    end else if (op_valid && is_class) begin
      {nxt_cc[3], nxt_cc[2], nxt_cc[0]} = cls_code;
      nxt_cc[1] = top_c.sign;
    end else if (op_valid && is_xch) begin
      nxt_fault.stack = xch_uflow;
      nxt_cc[1]       = 1'b0;
      // contents swap only when both entries hold values
      if (!xch_uflow) begin
        wa_en  = 1'b1;
        wa_dat = src_v;
        wb_en  = 1'b1;
        wb_dat = top_v;
      end
    end else if (op_valid && is_split) begin
      nxt_fault.stack    = spl_uflow || spl_oflow;
      nxt_fault.invalid  = spl_inv;
      nxt_fault.zero_div = spl_zero;
      nxt_fault.denormal = spl_den;
      nxt_cc[1]          = spl_oflow;
      if (spl_go) begin
        wa_en   = 1'b1;
        wa_dat  = spl_sec;
        nxt_top = p_push;
        wb_en   = 1'b1;
        wb_idx  = p_push;
        wb_dat  = spl_new;
      end
    end
  end

  // per entry storage: op writes win over the load port
  wire op_busy = op_valid && known_op;
  for (genvar e = 0; e < DEPTH; e++) begin : g_entry
    wire hit_a  = wa_en && wa_idx == 3'(e);
    wire hit_b  = wb_en && wb_idx == 3'(e);
    wire popped = (pop_n != 2'h0 && p_top == 3'(e))
               || (pop_n == 2'h2 && p_top + 3'h1 == 3'(e));
    wire hit_ld = load_valid && !op_busy && load_index == 3'(e);
    // data and tag of one entry
    always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
        regs_ff[e]  <= 80'h0;
        empty_ff[e] <= 1'b1;
      end else if (hit_b) begin
        regs_ff[e]  <= wb_dat;
        empty_ff[e] <= 1'b0;
      end else if (hit_a) begin
        regs_ff[e]  <= wa_dat;
        empty_ff[e] <= 1'b0;
      end else if (popped) begin
        empty_ff[e] <= 1'b1;
      end else if (hit_ld) begin
        regs_ff[e]  <= load_data;
        empty_ff[e] <= load_empty;
      end
    end
  end

  // pointer, condition code and pulses
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      top_ff      <= fpu_cmp_pkg::TOP_RST;
      cc_ff       <= fpu_cmp_pkg::CC_RST;
      fault_ff    <= '0;
      done_ff     <= 1'b0;
      rd_ff       <= 80'h0;
      rd_empty_ff <= 1'b1;
    end else begin
      top_ff      <= nxt_top;
      cc_ff       <= nxt_cc;
      fault_ff    <= nxt_fault;
      done_ff     <= op_busy;
      rd_ff       <= regs_ff[read_index];
      rd_empty_ff <= empty_ff[read_index];
    end
  end

  // outputs come straight from flops
  assign cond_code           = cc_ff;
  assign stack_pointer_field = top_ff;
  assign faults              = fault_ff;
  assign op_done             = done_ff;
  assign read_data           = rd_ff;
  assign read_empty          = rd_empty_ff;

  // checks on retired ops
  property p_unavail;
    @(posedge clk) disable iff (!rst_n)
    op_valid && known_op && blocked |=>
      fault_ff.unavail && $stable(top_ff) && $stable(cc_ff);
  endproperty
  a_unavail: assert property (p_unavail)
    else $error("blocked op changed state or missed unavailable fault");

  property p_pop2;
    @(posedge clk) disable iff (!rst_n)
    op_valid && !blocked && is_ucompp && cmp_go |=>
      top_ff == $past(top_ff) + 3'h2 && empty_ff[$past(p_top)];
  endproperty
  a_pop2: assert property (p_pop2)
    else $error("double pop did not advance pointer by two");

  property p_qnan;
    @(posedge clk) disable iff (!rst_n)
    op_valid && !blocked && is_cmp && cmp_nan && !cmp_inv && !cmp_uflow
      |=> !fault_ff.invalid && cc_ff[3] && cc_ff[2] && cc_ff[0];
  endproperty
  a_qnan: assert property (p_qnan)
    else $error("quiet nan compare not unordered or faulted");

  property p_unmasked;
    @(posedge clk) disable iff (!rst_n)
    op_valid && !blocked && is_cmp && cmp_inv && !invalid_op_mask
      |=> fault_ff.invalid && cc_ff[3:2] == $past(cc_ff[3:2])
          && cc_ff[0] == $past(cc_ff[0]);
  endproperty
  a_unmasked: assert property (p_unmasked)
    else $error("unmasked invalid compare wrote condition bits");

  property p_zero_eq;
    @(posedge clk) disable iff (!rst_n)
    op_valid && !blocked && is_cmp && both_zero
      |=> {cc_ff[3], cc_ff[2], cc_ff[0]} == fpu_cmp_pkg::CC_EQ;
  endproperty
  a_zero_eq: assert property (p_zero_eq)
    else $error("zero operands did not compare equal");

  property p_class_sign;
    @(posedge clk) disable iff (!rst_n)
    op_valid && !blocked && is_class
      |=> cc_ff[1] == $past(top_v[79]) && !fault_ff.invalid;
  endproperty
  a_class_sign: assert property (p_class_sign)
    else $error("classify sign bit not copied");

  property p_xch_c1;
    @(posedge clk) disable iff (!rst_n)
    op_valid && !blocked && is_xch
      |=> !cc_ff[1] && fault_ff.stack == $past(xch_uflow);
  endproperty
  a_xch_c1: assert property (p_xch_c1)
    else $error("exchange left cc_bit1 set");

  property p_split_push;
    @(posedge clk) disable iff (!rst_n)
    op_valid && !blocked && is_split && spl_go
      |=> top_ff == $past(top_ff) - 3'h1
          && (regs_ff[top_ff][78:64] == fpu_cmp_pkg::EXP_BIAS
              || $past(spl_zero)
              || $past(top_c.cls) == fpu_cmp_pkg::CLS_NAN);
  endproperty
  a_split_push: assert property (p_split_push)
    else $error("split did not push significand with biased zero exponent");

  property p_split_oflow;
    @(posedge clk) disable iff (!rst_n)
    op_valid && !blocked && is_split && spl_oflow
      |=> cc_ff[1] && fault_ff.stack && $stable(top_ff);
  endproperty
  a_split_oflow: assert property (p_split_oflow)
    else $error("split overflow not reported");

endmodule : fpu_compare_classify_exchange
`default_nettype wire

// *** sim/issue_model.sv ***
// issue_model: stands in for the decode and issue logic
// assumes the bench raises req for one cycle per instruction
`timescale 1ns/100ps
`default_nettype none

module issue_model (
  // clock and reset
  input  wire logic                 clk,
  input  wire logic                 rst_n,
  // request from the bench
  input  wire logic                 req,
  input  wire fpu_cmp_pkg::opcode_s req_op,
  // issue port of the slice
  output var  logic                 op_valid,
  output var  fpu_cmp_pkg::opcode_s opcode
);
  // one-cycle issue; idle opcode keeps toggling so nothing leans on it
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      op_valid <= 1'b0;
      opcode   <= '0;
    end else begin
      op_valid <= req;
      opcode   <= req ? req_op : ~opcode;
    end
  end
endmodule : issue_model
`default_nettype wire

// *** sim/fpu_compare_classify_exchange_tb.sv ***
// fpu_compare_classify_exchange_tb: directed tests of the stack slice
// assumes issue_model in front of the op port, 250 MHz clock
`timescale 1ns/100ps
`default_nettype none

module fpu_compare_classify_exchange_tb;
  // extended reals: sign, exponent, significand with int bit
  localparam logic [79:0] ONE   = 80'h3FFF_8000_0000_0000_0000;
  localparam logic [79:0] NONE  = 80'hBFFF_8000_0000_0000_0000;
  localparam logic [79:0] TWO   = 80'h4000_8000_0000_0000_0000;
  localparam logic [79:0] THREE = 80'h4000_C000_0000_0000_0000;
  localparam logic [79:0] EIGHT = 80'h4002_8000_0000_0000_0000;
  localparam logic [79:0] NZERO = 80'h8000_0000_0000_0000_0000;
  localparam logic [79:0] QNAN  = 80'h7FFF_C000_0000_0000_0000;
  localparam logic [79:0] SNAN  = 80'h7FFF_A000_0000_0000_0000;
  localparam logic [79:0] NINF  = 80'hFFFF_8000_0000_0000_0000;
  logic clk = 1'b0;
  logic rst_n, req, op_valid, op_done, read_empty;
  logic emulation_flag, task_switched_flag, invalid_op_mask;
  logic zero_divide_mask, load_valid, load_empty;
  logic [2:0]           load_index, read_index, stack_pointer_field;
  logic [79:0]          load_data, read_data, rv;
  logic [3:0]           cond_code;
  logic [2:0]           ccx;       // {cc_bit3, cc_bit2, cc_bit0}
  fpu_cmp_pkg::opcode_s req_op, opcode;
  fpu_cmp_pkg::fault_s  faults, fl; // fl: faults seen with op_done
  int                   n_errors, checks_done;
  assign ccx = {cond_code[3], cond_code[2], cond_code[0]};

  // 4 ns clock
  always #2 clk = ~clk;

  issue_model i_issue_model (.clk(clk), .rst_n(rst_n), .req(req),
    .req_op(req_op), .op_valid(op_valid), .opcode(opcode));
  fpu_compare_classify_exchange i_fpu_compare_classify_exchange (
    .clk(clk), .rst_n(rst_n), .op_valid(op_valid), .opcode(opcode),
    .emulation_flag(emulation_flag), .task_switched_flag(task_switched_flag),
    .invalid_op_mask(invalid_op_mask), .zero_divide_mask(zero_divide_mask),
    .load_valid(load_valid), .load_index(load_index),
    .load_data(load_data), .load_empty(load_empty),
    .read_index(read_index), .cond_code(cond_code),
    .stack_pointer_field(stack_pointer_field), .faults(faults),
    .op_done(op_done), .read_data(read_data), .read_empty(read_empty));

  // compare of entry values
  task automatic chk80(input logic [79:0] got, input logic [79:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk80
  // compare of flags, codes and pointers
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk8
  // write one physical entry
  task automatic load(input logic [2:0] i, input logic [79:0] d,
                      input logic e);
    @(posedge clk);
    load_valid <= 1'b1;
    load_index <= i;
    load_data  <= d;
    load_empty <= e;
    @(posedge clk);
    load_valid <= 1'b0;
  endtask : load
  // issue one op, catch the done pulse within a bounded wait
  task automatic op(input logic [7:0] hi, input logic [7:0] lo);
    logic seen;
    seen = 1'b0;
    @(posedge clk);
    req    <= 1'b1;
    req_op <= {hi, lo};
    @(posedge clk);
    req <= 1'b0;
    repeat (4) begin
      @(posedge clk);
      #1;
      if (!seen && op_done === 1'b1) begin
        seen = 1'b1;
        fl   = faults;
      end
    end
    chk8(8'(seen), 8'h01);
  endtask : op
  // read one physical entry, one edge of latency
  task automatic rd(input logic [2:0] i);
    @(posedge clk);
    read_index <= i;
    @(posedge clk);
    #1;
    rv = read_data;
  endtask : rd

  // split 8.0: exponent 3.0 stays below, 1.0 pushed on top
  task automatic t_split;
    load(3'h0, EIGHT, 1'b0);
    op(8'hD9, 8'hF4);
    chk8(8'(stack_pointer_field), 8'h07);
    chk8(8'(cond_code[1]), 8'h00);
    rd(3'h7);
    chk80(rv, ONE);
    rd(3'h0);
    chk80(rv, THREE);
    $display("split test done");
  endtask : t_split
  // classify a negative normal, then exchange must clear cc_bit1
  task automatic t_xchg;
    load(3'h7, NONE, 1'b0);
    op(8'hD9, 8'hE5);
    chk8(8'(cond_code), 8'h06);
    op(8'hD9, 8'hC9);
    chk8(8'(cond_code[1]), 8'h00);
    rd(3'h7);
    chk80(rv, THREE);
    rd(3'h0);
    chk80(rv, NONE);
    $display("exchange test done");
  endtask : t_xchg
  // plain, single-pop and double-pop compares
  task automatic t_cmp;
    op(8'hDD, 8'hE1);
    chk8(8'(ccx), 8'h00);
    op(8'hDD, 8'hE9);
    chk8(8'(stack_pointer_field), 8'h00);
    rd(3'h7);
    chk8(8'(read_empty), 8'h01);
    load(3'h1, TWO, 1'b0);
    op(8'hDA, 8'hE9);
    chk8(8'(ccx), 8'h01);
    chk8(8'(stack_pointer_field), 8'h02);
    $display("compare test done");
  endtask : t_cmp
  // signed zeros, unmasked signalling nan, quiet nan
  task automatic t_zero;
    load(3'h2, NZERO, 1'b0);
    load(3'h3, 80'h0, 1'b0);
    op(8'hDD, 8'hE1);
    chk8(8'(ccx), 8'h04);
    load(3'h3, SNAN, 1'b0);
    op(8'hDD, 8'hE1);
    chk8(8'(fl.invalid), 8'h01);
    chk8(8'(ccx), 8'h04);
    load(3'h3, QNAN, 1'b0);
    op(8'hDD, 8'hE1);
    chk8(8'(ccx), 8'h07);
    chk8(8'(fl.invalid), 8'h00);
    $display("zero and nan test done");
  endtask : t_zero
  // class of negative zero, then of an empty entry with sign set
  task automatic t_class;
    op(8'hD9, 8'hE5);
    chk8(8'(cond_code), 8'h0A);
    load(3'h2, NZERO, 1'b1);
    op(8'hD9, 8'hE5);
    chk8(8'(cond_code), 8'h0B);
    $display("classify test done");
  endtask : t_class
  // underflow, split overflow, masked zero split, masked snan compare
  task automatic t_fault;
    op(8'hDD, 8'hE1);
    chk8(8'(fl), 8'h04);
    chk8(8'(cond_code), 8'h09);
    load(3'h2, ONE, 1'b0);
    load(3'h1, ONE, 1'b0);
    op(8'hD9, 8'hF4);
    chk8(8'(fl), 8'h04);
    chk8(8'(cond_code), 8'h0B);
    chk8(8'(stack_pointer_field), 8'h02);
    @(posedge clk);
    {invalid_op_mask, zero_divide_mask} <= 2'h3;
    load(3'h2, NZERO, 1'b0);
    load(3'h1, ONE, 1'b1);
    op(8'hD9, 8'hF4);
    chk8(8'(fl), 8'h01);
    rd(3'h2);
    chk80(rv, NINF);
    rd(3'h1);
    chk80(rv, NZERO);
    load(3'h2, SNAN, 1'b0);
    op(8'hDD, 8'hE9);
    chk8(8'(fl), 8'h08);
    chk8(8'(ccx), 8'h07);
    chk8(8'(stack_pointer_field), 8'h02);
    $display("fault test done");
  endtask : t_fault
  // each blocking flag alone turns an op into a fault only
  task automatic t_block;
    @(posedge clk);
    emulation_flag <= 1'b1;
    op(8'hDD, 8'hE9);
    chk8(8'(fl), 8'h10);
    chk8(8'(stack_pointer_field), 8'h02);
    @(posedge clk);
    emulation_flag     <= 1'b0;
    task_switched_flag <= 1'b1;
    op(8'hD9, 8'hE5);
    chk8(8'(fl), 8'h10);
    $display("blocking test done");
  endtask : t_block

  // verdict and end of run
  task automatic close_out;
    $display("checks %0d mismatches %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : close_out

  // main sequence
  initial begin
    {rst_n, req, emulation_flag, task_switched_flag} = '0;
    {invalid_op_mask, zero_divide_mask, load_valid, load_empty} = '0;
    {load_index, read_index, load_data, req_op} = '0;
    {n_errors, checks_done} = '0;
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    t_split;
    t_xchg;
    t_cmp;
    t_zero;
    t_class;
    t_fault;
    t_block;
    close_out;
  end
  // watchdog: tests need well under 1000 cycles
  initial begin
    #20000;
    n_errors++;
    close_out;
  end
endmodule : fpu_compare_classify_exchange_tb
`default_nettype wire
